// ===== shared/csc_pkg.sv
// Package: register map, field positions and carrier types of the conversion sequence control
package csc_pkg;
  localparam logic [3:0] CSC_ADDR_CTRL = 4'h0;
  localparam logic [3:0] CSC_ADDR_STATUS = 4'h4;
  localparam logic [3:0] CSC_ADDR_CHAN = 4'h8;
  localparam int CSC_POS_JUSTIFY = 7;
  localparam int CSC_POS_SIGNED = 6;
  localparam int CSC_POS_SCAN = 5;
  localparam int CSC_POS_MULTI = 4;
  localparam int CSC_POS_RSVD = 3;
  localparam logic [7:0] CSC_CTRL_RESET = 8'h00;
  localparam logic [7:0] CSC_CTRL_WMASK = 8'hF7;
  localparam logic [2:0] CSC_CHAN_MAX = 3'h7;
  localparam logic [3:0] CSC_LEN_ONE = 4'h1;

  typedef struct packed {
    logic justify_right;
    logic signed_fmt;
    logic scan;
    logic multi;
    logic [2:0] chan_start;
  } csc_cfg_t;

  typedef struct packed {
    logic valid;
    logic [2:0] chan;
    logic justify_right;
    logic signed_fmt;
    logic abort;
  } csc_conv_req_t;

  typedef enum logic [1:0] {
    CSC_IDLE = 2'b00,
    CSC_REQ = 2'b01,
    CSC_WAIT = 2'b10
  } csc_state_t;
endpackage : csc_pkg

// ===== logic/csc_chan_step.sv
// Channel code stepper for multi-channel sequences
`timescale 1ns/100ps
`default_nettype none
module csc_chan_step
  import csc_pkg::*;
(
  input wire logic [2:0] cur,
  input wire logic multi,
  output logic [2:0] nxt
);
  // Explicit compare wraps from the top code back to zero; a clear multi bit holds the code
  assign nxt = multi ? ((cur == CSC_CHAN_MAX) ? 3'h0 : 3'(cur + 3'h1)) : cur; // [RL8] [RL9]
endmodule : csc_chan_step
`default_nettype wire

// ===== logic/csc_seq_ctrl.sv
// Conversion sequence controller with Avalon-MM register slave
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// RL1: Any control write aborts the running sequence and starts a new one.
// RL2: Bit 7 clear gives left justified results, set gives right justified.
// RL3: Bit 6 clear gives unsigned results, set gives two's complement signed.
// RL4: Signed format is never applied to right justified results.
// RL5: Bit 5 clear runs one sequence, set repeats sequences continuously.
// RL6: Multi bit clear converts the selected channel for the whole sequence.
// RL7: Multi bit set converts a different channel each time, sequence length many.
// RL8: First channel is the code in bits 2 to 0, then incremented by one.
// RL9: Channel code wraps from its largest to its smallest value.
// RL10: Sequence length comes from a separate configuration input.
// RL11: Register readable and writable anytime; bit 3 reads zero, ignores writes.
module csc_seq_ctrl
  import csc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [3:0] seq_length,
  input wire logic conv_done,
  output csc_conv_req_t conv_req,
  output logic seq_active,
  output logic seq_complete
);
  logic [7:0] ctrl_r;
  csc_state_t state_r;
  csc_state_t state_nxt;
  logic [2:0] chan_r;
  logic [2:0] chan_nxt;
  logic [3:0] count_r;
  logic ack_r;
  logic wait_r;
  logic [31:0] rdata_r;
  csc_conv_req_t req_r;
  logic complete_r;
  logic restart_r;

  function automatic logic [3:0] seq_len_eff(input logic [3:0] len, input logic multi);
    // Zero length is treated as one conversion so a sequence always ends
    seq_len_eff = (len == 4'h0) ? CSC_LEN_ONE : len; // [RL10]
  endfunction : seq_len_eff

  // Bus decode; one wait state per access so every request sees waitrequest high once
  wire access = (avs_read | avs_write) & ~ack_r;
  wire hit_ctrl = (avs_address == CSC_ADDR_CTRL);
  wire hit_status = (avs_address == CSC_ADDR_STATUS);
  wire hit_chan = (avs_address == CSC_ADDR_CHAN);
  // The write lands at the edge where waitrequest is seen low, as the master expects
  wire ctrl_wr = ack_r & avs_write & hit_ctrl & avs_byteenable[0]; // [RL11]
  wire [7:0] ctrl_wval = avs_writedata[7:0] & CSC_CTRL_WMASK; // [RL11]

  csc_cfg_t cfg;
  assign cfg = '{justify_right: ctrl_r[CSC_POS_JUSTIFY], signed_fmt: ctrl_r[CSC_POS_SIGNED],
                 scan: ctrl_r[CSC_POS_SCAN], multi: ctrl_r[CSC_POS_MULTI], chan_start: ctrl_r[2:0]};

  wire [3:0] len_eff = seq_len_eff(seq_length, cfg.multi);
  wire last_conv = (count_r == 4'(len_eff - 4'h1));
  wire step_done = (state_r == CSC_WAIT) & conv_done;

  csc_chan_step u_step (
    .cur(chan_r),
    .multi(cfg.multi), // [RL6] [RL7]
    .nxt(chan_nxt)
  );

  wire [31:0] rd_mux = hit_ctrl ? {24'h0000_00, ctrl_r} :
                       hit_status ? {24'h0000_00, count_r, 2'b00, complete_r, seq_active} :
                       hit_chan ? {29'h0000_0000, chan_r} : 32'h0000_0000;

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      CSC_IDLE: state_nxt = restart_r ? CSC_REQ : CSC_IDLE;
      CSC_REQ: state_nxt = CSC_WAIT;
      CSC_WAIT:
      begin
        if (conv_done)
        begin
          if (!last_conv || cfg.scan) // [RL5]
            state_nxt = CSC_REQ;
          else
            state_nxt = CSC_IDLE;
        end
      end
      default: state_nxt = CSC_IDLE;
    endcase
    if (restart_r)
      state_nxt = CSC_REQ; // [RL1]
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ack_r <= 1'b0;
      wait_r <= 1'b1;
      rdata_r <= 32'h0000_0000;
    end
    else
    begin
      ack_r <= access;
      wait_r <= ~access;
      rdata_r <= (access & avs_read) ? rd_mux : rdata_r;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      ctrl_r <= CSC_CTRL_RESET;
    else if (ctrl_wr)
      ctrl_r <= ctrl_wval; // [RL11]
  end

  // Restart is taken one cycle after the write so the new settings are in place
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      restart_r <= 1'b0;
    else
      restart_r <= ctrl_wr; // [RL1]
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_r <= CSC_IDLE;
      chan_r <= 3'h0;
      count_r <= 4'h0;
    end
    else
    begin
      state_r <= state_nxt;
      if (restart_r)
      begin
        chan_r <= cfg.chan_start; // [RL1] [RL8]
        count_r <= 4'h0;
      end
      else if (step_done)
      begin
        // A new scan pass restarts at the start code, not the wrapped one
        chan_r <= last_conv ? cfg.chan_start : chan_nxt; // [RL7] [RL9]
        count_r <= last_conv ? 4'h0 : 4'(count_r + 4'h1); // [RL7]
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      req_r <= '0;
      complete_r <= 1'b0;
    end
    else
    begin
      req_r.valid <= (state_r == CSC_REQ) & ~restart_r;
      req_r.chan <= chan_r; // [RL6]
      req_r.justify_right <= cfg.justify_right; // [RL2]
      req_r.signed_fmt <= cfg.signed_fmt & ~cfg.justify_right; // [RL3] [RL4]
      req_r.abort <= restart_r; // [RL1]
      if (restart_r)
        complete_r <= 1'b0;
      else if (step_done & last_conv & ~cfg.scan)
        complete_r <= 1'b1; // [RL5]
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      seq_active <= 1'b0;
    else
      seq_active <= (state_nxt != CSC_IDLE);
  end

  assign avs_readdata = rdata_r;
  assign avs_waitrequest = wait_r;
  assign conv_req = req_r;
  assign seq_complete = complete_r;
endmodule : csc_seq_ctrl
`default_nettype wire

// ===== verif/csc_front_model.sv
// Front end model: ends each conversion after a short or long delay
`timescale 1ns/100ps
`default_nettype none
module csc_front_model
  import csc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic slow,
  input wire csc_conv_req_t conv_req,
  output logic conv_done
);
  logic [3:0] t_r;
  assign conv_done = t_r == 4'h1;
  // An abort drops the conversion, so no stale done reaches the new run
  always_ff @(posedge sys_clk or negedge nrst)
    if (!nrst)
      t_r <= 4'h0;
    else if (conv_req.abort)
      t_r <= 4'h0;
    else if (conv_req.valid)
      t_r <= slow ? 4'h9 : 4'h2;
    else if (t_r != 4'h0)
      t_r <= t_r - 4'h1;
endmodule : csc_front_model
`default_nettype wire

// ===== verif/csc_seq_ctrl_assertions.sv
// Port checks for the conversion sequence controller
`timescale 1ns/100ps
`default_nettype none
module csc_seq_ctrl_assertions
  import csc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [3:0] seq_length,
  input wire csc_conv_req_t conv_req
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  logic [7:0] p_r, c_r, n_r;
  wire wr = avs_write && !avs_waitrequest && avs_address == CSC_ADDR_CTRL;
  wire v = conv_req.valid;
  wire [3:0] len = seq_length == 4'h0 ? CSC_LEN_ONE : seq_length;
  wire [2:0] ch = 3'(c_r[2:0] + n_r % len);
  // Settings count from the abort, so late results of the old run keep the old ones
  always_ff @(posedge sys_clk or negedge nrst)
    if (!nrst)
      {p_r, c_r, n_r} <= '0;
    else
    begin
      p_r <= wr ? avs_writedata[7:0] : p_r;
      c_r <= conv_req.abort ? p_r : c_r;
      n_r <= conv_req.abort ? 8'h00 : n_r + 8'(v);
    end
  sequence s_abort;
    ##[1:3] conv_req.abort;
  endsequence
  chk_wr_abort: assert property (wr |-> s_abort) else $error("no abort");
  chk_justify: assert property (v |-> conv_req.justify_right == c_r[7]) else $error("justify");
  chk_sign_fmt: assert property (v |-> conv_req.signed_fmt == (c_r[6] && !c_r[7])) else $error("sign");
  chk_fixed_chan: assert property (v && !c_r[4] |-> conv_req.chan == c_r[2:0]) else $error("chan");
  chk_chan_step: assert property (v && c_r[4] |-> conv_req.chan == ch) else $error("step");
  chk_single_len: assert property (v && !c_r[5] |-> n_r < len) else $error("count");
  chk_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("wait");
  chk_ctrl_read: assert property (avs_read && !avs_waitrequest && avs_address == CSC_ADDR_CTRL
    |-> avs_readdata == {24'h00_0000, p_r & CSC_CTRL_WMASK}) else $error("read");
endmodule : csc_seq_ctrl_assertions
bind csc_seq_ctrl csc_seq_ctrl_assertions u_chk (.*);
`default_nettype wire

// ===== verif/testbench.sv
// Self-checking bench for the conversion sequence controller
`timescale 1ns/100ps
`default_nettype none
module testbench
  import csc_pkg::*;
;
  logic sys_clk = 0, nrst = 0, avs_read = 0, avs_write = 0, slow = 0;
  logic avs_waitrequest, seq_active, seq_complete, conv_done;
  logic [3:0] avs_address = 0, avs_byteenable = 4'h1, seq_length = 4'h4;
  logic [31:0] avs_writedata = 0, avs_readdata, q;
  csc_conv_req_t conv_req;
  int num_errors, cmp_count, nv;
  // Address, written byte, expected read
  logic [19:0] rows [4] = '{20'h0_FFF7, 20'h0_0800, 20'h0_D6D6, 20'hC_5600};
  always #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) nv <= conv_req.abort ? 0 : nv + conv_req.valid;
  csc_seq_ctrl u_csc_seq_ctrl (.*);
  csc_front_model u_csc_front_model (.*);
  task automatic chk(input logic [31:0] g, e);
    cmp_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= {24'h00_0000, d};
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 0;
    avs_read <= 0;
    @(posedge sys_clk);
  endtask : bus
  task automatic run(input logic [7:0] d, input int n);
    bus(1, CSC_ADDR_CTRL, d);
    repeat (3) @(posedge sys_clk);
    repeat (300) if (seq_complete !== 1'b1) @(posedge sys_clk);
    chk(seq_complete, 1);
    chk(nv, n);
    chk(seq_active, 0);
  endtask : run
  task automatic finish_test;
    if (num_errors == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : finish_test
  initial
  begin
    repeat (3) @(posedge sys_clk);
    nrst <= 1;
    bus(0, CSC_ADDR_CTRL, 0);
    chk(q, 0);
    foreach (rows[i])
    begin
      bus(1, CSC_ADDR_CTRL, rows[i][15:8]);
      bus(0, rows[i][19:16], 0);
      chk(q, rows[i][7:0]);
      repeat (40) @(posedge sys_clk);
    end
    slow <= 1;
    run(8'h16, 4);
    bus(1, CSC_ADDR_CTRL, 8'h36);
    @(posedge sys_clk);
    chk(seq_active, 1);
    run(8'h11, 4);
    seq_length <= 0;
    run(8'h05, 1);
    finish_test;
  end
  initial
  begin
    #100000;
    num_errors++;
    finish_test;
  end
endmodule : testbench
`default_nettype wire
